// [hdl/xconn_map.vh]
// Purpose: Constants of the timeslot cross-connect
// Assumes: Included by bare name from the design files
// Notes:   Offsets and counts as defines
`ifndef XCONN_MAP_VH
`define XCONN_MAP_VH
// Sizes
`define N_IN            4
`define N_OUT           4
`define ID_W            2
`define BYTE_W          8
`define BIT_CNT_W       3
// Idle codes, A-law and mu-law
`define IDLE_A_LAW      8'hD5
`define IDLE_MU_LAW     8'hFF
// Management command codes
`define CMD_CONNECT     2'h1
`define CMD_RELEASE     2'h2
// Traffic direction attribute
`define DIR_UNI         1'b0
`define DIR_BI          1'b1
// Register offsets
`define REG_CTRL        4'h0
`define REG_CMD         4'h1
`define REG_STATUS      4'h2
`define REG_MAP0        4'h4
// Control field positions and reset value
`define CTRL_MU_LAW     0
`define CTRL_SRC_SEL_LO 4
`define CTRL_SINK_EN_LO 8
`define CTRL_RESET_VAL  32'h00000F00
// Command field positions
`define CMD_OP_LO       0
`define CMD_IN_LO       4
`define CMD_OUT_LO      8
`define CMD_DIR_BIT     12
`endif

// [hdl/byte_deser.v]
// Purpose: Collects one input channel's bits into bytes
// Assumes: Clock, data, marker and fail flag already synchronised
// Notes:   Marker high on the clock edge of bit one
`timescale 1ns/10ps
`include "xconn_map.vh"
module byte_deser (
    // Clock and reset
    input  wire        mclk_i,
    input  wire        sys_rst_i,
    // Synchronised channel
    input  wire        bit_clk_i,
    input  wire        data_i,
    input  wire        marker_i,
    input  wire        fail_i,
    // Completed byte
    output reg  [7:0]  byte_o,
    output reg         fail_o,
    output reg         valid_o
);
    reg                bit_clk_d_ff;
    reg  [7:0]         shift_ff;
    reg  [2:0]         cnt_ff;
    wire               rise;
    wire [2:0]         nxt_cnt;

    assign rise    = bit_clk_i & ~bit_clk_d_ff;
    assign nxt_cnt = marker_i ? 3'h1 : cnt_ff + 3'h1;

    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bit_clk_d_ff <= 1'b0;
            shift_ff     <= 8'h00;
            cnt_ff       <= 3'h0;
            byte_o       <= 8'h00;
            fail_o       <= 1'b0;
            valid_o      <= 1'b0;
        end else begin
            bit_clk_d_ff <= bit_clk_i;
            valid_o      <= 1'b0;
            if (rise) begin
                // Bit one arrives first, sits in the MSB
                shift_ff <= {shift_ff[6:0], data_i};
                cnt_ff   <= nxt_cnt;
                if (nxt_cnt == 3'h0) begin
                    byte_o  <= {shift_ff[6:0], data_i};
                    fail_o  <= fail_i;
                    valid_o <= 1'b1;
                end
            end
        end
    end
endmodule // byte_deser

// [hdl/timeslot_cross_connect.v]
// Purpose: 64 kbit/s byte channel cross-connect with idle generation
// Assumes: Channel and equipment timing inputs are asynchronous pins
// Notes:   Channel outputs retimed to equipment clock; connection and idle code changes take effect at bytes
`timescale 1ns/10ps
`include "xconn_map.vh"
module timeslot_cross_connect (
    // Clock and reset
    input  wire        mclk_i,
    input  wire        sys_rst_i,
    // Register port
    input  wire [3:0]  reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [31:0] reg_rdata_o,
    // Input channels
    input  wire [3:0]  channel_data_i,
    input  wire [3:0]  channel_bit_clock_i,
    input  wire [3:0]  channel_frame_marker_i,
    input  wire [3:0]  channel_fail_flag_i,
    // Equipment timing
    input  wire        equipment_timing_clock_i,
    input  wire        equipment_frame_marker_i,
    // Output channels
    output reg  [3:0]  channel_data_o,
    output wire [3:0]  channel_bit_clock_o,
    output reg  [3:0]  channel_frame_marker_o,
    output reg  [3:0]  channel_fail_flag_o,
    // Access point adaptation activation
    output reg  [3:0]  src_enable_o,
    output reg  [3:0]  sink_enable_o
);
    // Synchronisers
    reg  [3:0]         s1_dat_ff;
    reg  [3:0]         s2_dat_ff;
    reg  [3:0]         s1_clk_ff;
    reg  [3:0]         s2_clk_ff;
    reg  [3:0]         s1_mrk_ff;
    reg  [3:0]         s2_mrk_ff;
    reg  [3:0]         s1_ssf_ff;
    reg  [3:0]         s2_ssf_ff;
    reg                s1_eclk_ff;
    reg                s2_eclk_ff;
    reg                s1_emrk_ff;
    reg                s2_emrk_ff;
    reg                eclk_d_ff;

    // Received byte stores
    wire [31:0]        rx_byte;
    wire [3:0]         rx_fail;
    wire [3:0]         rx_valid;
    reg  [7:0]         hold_byte_ff [0:3];
    reg  [3:0]         hold_fail_ff;

    // Connection tables
    reg  [3:0]         conn_valid_ff;
    reg  [1:0]         conn_src_ff  [0:3];
    reg  [3:0]         conn_dir_ff;
    reg  [3:0]         pend_valid_ff;
    reg  [1:0]         pend_src_ff  [0:3];
    reg  [3:0]         pend_dir_ff;
    reg  [3:0]         pend_chg_ff;

    // Control
    reg                mu_law_ff;
    reg  [1:0]         src_sel_ff;
    reg  [3:0]         sink_en_ff;
    reg  [31:0]        rdata_nxt;

    // Output serialiser
    reg  [7:0]         tx_byte_ff [0:3];
    reg  [3:0]         tx_fail_ff;
    reg                tx_first_ff;
    reg  [2:0]         tx_cnt_ff;
    wire               erise;
    wire               efall;
    wire               frame_start;
    wire [7:0]         idle_code;
    integer            i;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : rx
            byte_deser u_deser (
                .mclk_i    (mclk_i),
                .sys_rst_i (sys_rst_i),
                .bit_clk_i (s2_clk_ff[g]),
                .data_i    (s2_dat_ff[g]),
                .marker_i  (s2_mrk_ff[g]),
                .fail_i    (s2_ssf_ff[g]),
                .byte_o    (rx_byte[g*8 +: 8]),
                .fail_o    (rx_fail[g]),
                .valid_o   (rx_valid[g])
            );
        end
    endgenerate

    function [3:0] onehot;
        input [1:0] idx;
        begin
            onehot = 4'h1 << idx;
        end
    endfunction

    // Two-bit field of a written word
    function [1:0] field2;
        input [31:0] word;
        input integer lo;
        begin
            field2 = word[lo +: 2];
        end
    endfunction

    // Write strobe aimed at one register
    function reg_hit;
        input       wr;
        input [3:0] addr;
        input [3:0] want;
        begin
            reg_hit = wr && (addr == want);
        end
    endfunction

    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1_dat_ff  <= 4'h0;
            s2_dat_ff  <= 4'h0;
            s1_clk_ff  <= 4'h0;
            s2_clk_ff  <= 4'h0;
            s1_mrk_ff  <= 4'h0;
            s2_mrk_ff  <= 4'h0;
            s1_ssf_ff  <= 4'h0;
            s2_ssf_ff  <= 4'h0;
            s1_eclk_ff <= 1'b0;
            s2_eclk_ff <= 1'b0;
            s1_emrk_ff <= 1'b0;
            s2_emrk_ff <= 1'b0;
            eclk_d_ff  <= 1'b0;
        end else begin
            s1_dat_ff  <= channel_data_i;
            s2_dat_ff  <= s1_dat_ff;
            s1_clk_ff  <= channel_bit_clock_i;
            s2_clk_ff  <= s1_clk_ff;
            s1_mrk_ff  <= channel_frame_marker_i;
            s2_mrk_ff  <= s1_mrk_ff;
            s1_ssf_ff  <= channel_fail_flag_i;
            s2_ssf_ff  <= s1_ssf_ff;
            s1_eclk_ff <= equipment_timing_clock_i;
            s2_eclk_ff <= s1_eclk_ff;
            s1_emrk_ff <= equipment_frame_marker_i;
            s2_emrk_ff <= s1_emrk_ff;
            eclk_d_ff  <= s2_eclk_ff;
        end
    end

    // Output clock edges come from equipment timing only
    assign erise       = s2_eclk_ff & ~eclk_d_ff;
    assign efall       = ~s2_eclk_ff & eclk_d_ff;
    assign frame_start = erise & s2_emrk_ff;
    assign idle_code   = mu_law_ff ? `IDLE_MU_LAW : `IDLE_A_LAW;
    assign channel_bit_clock_o = {4{eclk_d_ff}};

    // Latest complete byte per input
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hold_fail_ff <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                hold_byte_ff[i] <= 8'h00;
            end
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (rx_valid[i]) begin
                    hold_byte_ff[i] <= rx_byte[i*8 +: 8];
                    hold_fail_ff[i] <= rx_fail[i];
                end
            end
        end
    end

    // Management and staged connection table
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mu_law_ff     <= 1'b0;
            src_sel_ff    <= 2'h0;
            sink_en_ff    <= 4'hF;
            conn_valid_ff <= 4'h0;
            conn_dir_ff   <= 4'h0;
            pend_valid_ff <= 4'h0;
            pend_dir_ff   <= 4'h0;
            pend_chg_ff   <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                conn_src_ff[i] <= 2'h0;
                pend_src_ff[i] <= 2'h0;
            end
        end else begin
            // Staged entries commit at the equipment byte start
            if (frame_start) begin
                for (i = 0; i < 4; i = i + 1) begin
                    if (pend_chg_ff[i]) begin
                        conn_valid_ff[i] <= pend_valid_ff[i];
                        conn_src_ff[i]   <= pend_src_ff[i];
                        conn_dir_ff[i]   <= pend_dir_ff[i];
                    end
                end
                pend_chg_ff <= 4'h0;
            end
            if (reg_hit(reg_wr_i, reg_addr_i, `REG_CTRL)) begin
                mu_law_ff  <= reg_wdata_i[`CTRL_MU_LAW];
                src_sel_ff <= field2(reg_wdata_i, `CTRL_SRC_SEL_LO);
                sink_en_ff <= reg_wdata_i[`CTRL_SINK_EN_LO +: 4];
            end
            if (reg_hit(reg_wr_i, reg_addr_i, `REG_CMD)) begin
                // Only the named output entry changes
                for (i = 0; i < 4; i = i + 1) begin
                    if (field2(reg_wdata_i, `CMD_OUT_LO) == i[1:0]) begin
                        if (field2(reg_wdata_i, `CMD_OP_LO) == `CMD_CONNECT) begin
                            pend_valid_ff[i] <= 1'b1;
                            pend_src_ff[i]   <= field2(reg_wdata_i, `CMD_IN_LO);
                            pend_dir_ff[i]   <= reg_wdata_i[`CMD_DIR_BIT];
                            pend_chg_ff[i]   <= 1'b1;
                        end else if (field2(reg_wdata_i, `CMD_OP_LO) == `CMD_RELEASE) begin
                            pend_valid_ff[i] <= 1'b0;
                            pend_dir_ff[i]   <= `DIR_UNI;
                            pend_chg_ff[i]   <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    // Access point activation
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            src_enable_o  <= 4'h1;
            sink_enable_o <= 4'hF;
        end else begin
            src_enable_o  <= onehot(src_sel_ff);
            sink_enable_o <= sink_en_ff;
        end
    end

    // Retimed serialiser
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_cnt_ff              <= 3'h0;
            tx_first_ff            <= 1'b0;
            tx_fail_ff             <= 4'h0;
            channel_data_o         <= 4'h0;
            channel_frame_marker_o <= 4'h0;
            channel_fail_flag_o    <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                tx_byte_ff[i] <= 8'h00;
            end
        end else if (efall) begin
            // Drive on falling edge so the far end samples on the rise
            tx_cnt_ff   <= tx_cnt_ff + 3'h1;
            tx_first_ff <= 1'b0;
            // Marker stands over the rise that samples bit one
            channel_frame_marker_o <= {4{tx_first_ff}};
            if (tx_first_ff) begin
                channel_fail_flag_o <= tx_fail_ff;
            end
            for (i = 0; i < 4; i = i + 1) begin
                channel_data_o[i] <= tx_byte_ff[i][3'h7 - tx_cnt_ff];
            end
        end else if (frame_start) begin
            tx_cnt_ff   <= 3'h0;
            tx_first_ff <= 1'b1;
            for (i = 0; i < 4; i = i + 1) begin
                if (conn_valid_ff[i]) begin
                    tx_byte_ff[i] <= hold_byte_ff[conn_src_ff[i]];
                    tx_fail_ff[i] <= hold_fail_ff[conn_src_ff[i]];
                end else begin
                    tx_byte_ff[i] <= idle_code;
                    tx_fail_ff[i] <= 1'b0;
                end
            end
        end
    end

    // Register read
    always @* begin
        rdata_nxt = 32'h00000000;
        case (reg_addr_i)
            `REG_CTRL: begin
                rdata_nxt[`CTRL_MU_LAW]          = mu_law_ff;
                rdata_nxt[`CTRL_SRC_SEL_LO +: 2] = src_sel_ff;
                rdata_nxt[`CTRL_SINK_EN_LO +: 4] = sink_en_ff;
            end
            `REG_STATUS: begin
                rdata_nxt[3:0] = conn_valid_ff;
                rdata_nxt[7:4] = pend_chg_ff;
                rdata_nxt[11:8] = conn_dir_ff;
            end
            `REG_MAP0: begin
                for (i = 0; i < 4; i = i + 1) begin
                    rdata_nxt[i*4 +: 2] = conn_src_ff[i];
                end
            end
            default: begin
                rdata_nxt = 32'h00000000;
            end
        endcase
    end

    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_nxt;
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end
endmodule // timeslot_cross_connect

// [tb/xconn_sva.sv]
// Purpose: Port assertions for the cross-connect
// Assumes: Bound to timeslot_cross_connect
// Notes:   Output bit clock is the equipment clock 3 cycles late
`timescale 1ns/10ps
module xconn_sva (
    // Watched ports
    input wire        mclk_i,
    input wire        sys_rst_i,
    input wire [3:0]  reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire        reg_wr_i,
    input wire        reg_rd_i,
    input wire [31:0] reg_rdata_o,
    input wire        equipment_timing_clock_i,
    input wire [3:0]  channel_data_o,
    input wire [3:0]  channel_bit_clock_o,
    input wire [3:0]  channel_frame_marker_o,
    input wire [3:0]  channel_fail_flag_o,
    input wire [3:0]  src_enable_o,
    input wire [3:0]  sink_enable_o
);
    wire       ctl_w = reg_wr_i && reg_addr_i == 4'h0;
    reg  [3:0] rises_ff;
    reg        seen_ff;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // Bit clock rises since the last byte start
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rises_ff <= 4'h0;
            seen_ff  <= 1'b0;
        end else if ($rose(channel_frame_marker_o[0])) begin
            rises_ff <= {3'h0, $rose(channel_bit_clock_o[0])};
            seen_ff  <= 1'b1;
        end else if ($rose(channel_bit_clock_o[0])) begin
            rises_ff <= rises_ff + 4'h1;
        end
    end
    sequence s_hold;
        $stable(channel_data_o) ##1 $stable(channel_data_o);
    endsequence
    a_src_onehot: assert property ($onehot(src_enable_o))
        else $error("source enables not one-hot");
    a_src_select: assert property (ctl_w |=> ##1
        src_enable_o == 4'h1 << $past(reg_wdata_i[5:4], 2)) else $error("bad source select");
    a_sink_enables: assert property (ctl_w |=> ##1
        sink_enable_o == $past(reg_wdata_i[11:8], 2)) else $error("bad sink enables");
    a_read_quiet: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data outside answer");
    a_clk_retimed: assert property (!$past(sys_rst_i, 3) |->
        channel_bit_clock_o == {4{$past(equipment_timing_clock_i, 3)}})
        else $error("output clock not retimed");
    a_byte_eight: assert property ($rose(channel_frame_marker_o[0]) && seen_ff |->
        rises_ff == 4'h8) else $error("byte start not eight bits apart");
    a_data_hold: assert property ($rose(channel_bit_clock_o[0]) |-> s_hold)
        else $error("data moved at clock rise");
    a_fail_at_byte: assert property ($changed(channel_fail_flag_o) |->
        channel_frame_marker_o[0] || $past(channel_frame_marker_o[0]))
        else $error("fail flag moved mid-byte");
endmodule // xconn_sva

bind timeslot_cross_connect xconn_sva u_sva (.mclk_i, .sys_rst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .equipment_timing_clock_i,
    .channel_data_o, .channel_bit_clock_o, .channel_frame_marker_o, .channel_fail_flag_o,
    .src_enable_o, .sink_enable_o);

// [tb/chan_source.sv]
// Purpose: Far-side channel sources and equipment timing
// Assumes: Both clocks free-running at 400 ns, apart in phase
// Notes:   Each channel repeats its byte from pat_i, bit one first
`timescale 1ns/10ps
module chan_source (
    // Bench stimulus
    input wire [31:0] pat_i,
    input wire [3:0]  fail_i,
    // Channel and timing pins
    output reg [3:0]  data_o,
    output reg [3:0]  bclk_o,
    output reg [3:0]  mark_o,
    output reg [3:0]  fail_o,
    output reg        eq_clk_o,
    output reg        eq_mark_o
);
    integer b, k;
    // Bits change on the falling edge, marker spans bit one
    initial begin
        {data_o, bclk_o, mark_o, fail_o, eq_clk_o, eq_mark_o} = 18'h0;
        b = 7;
        #31;
        forever begin
            #158 eq_clk_o = 1'b1;
            #42 bclk_o = 4'hF;
            #158 eq_clk_o = 1'b0;
            #42 bclk_o = 4'h0;
            b = (b + 1) % 8;
            eq_mark_o = b == 3;
            mark_o = {4{b == 0}};
            if (b == 7) fail_o = fail_i;
            for (k = 0; k < 4; k = k + 1) data_o[k] = pat_i[8 * k + 7 - b];
        end
    end
endmodule // chan_source

// [tb/tb_timeslot_cross_connect.sv]
// Purpose: Self-checking bench for the cross-connect
// Assumes: chan_source drives channels and equipment timing
// Notes:   Output bytes are rebuilt from the serial stream
`timescale 1ns/10ps
`include "xconn_map.vh"
module tb_timeslot_cross_connect;
    reg         mclk_i, sys_rst_i, wr_i, rd_i, pclk, watch;
    reg  [3:0]  addr, fail_in, bc;
    reg  [31:0] wdata, pat, seed, shv, last;
    reg  [7:0]  exp0;
    reg  [1:0]  a_in, a_out;
    integer     nb, failures, num_checks, k, m;
    wire [31:0] rdata;
    wire [3:0]  di, ci, mi, fi, d_o, c_o, m_o, f_o, src_o, snk_o;
    wire        eq_clk, eq_mark;
    timeslot_cross_connect DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr_i), .reg_rd_i(rd_i), .reg_rdata_o(rdata),
        .channel_data_i(di), .channel_bit_clock_i(ci), .channel_frame_marker_i(mi),
        .channel_fail_flag_i(fi), .equipment_timing_clock_i(eq_clk),
        .equipment_frame_marker_i(eq_mark), .channel_data_o(d_o),
        .channel_bit_clock_o(c_o), .channel_frame_marker_o(m_o),
        .channel_fail_flag_o(f_o), .src_enable_o(src_o), .sink_enable_o(snk_o));
    chan_source u_src (.pat_i(pat), .fail_i(fail_in), .data_o(di), .bclk_o(ci),
        .mark_o(mi), .fail_o(fi), .eq_clk_o(eq_clk), .eq_mark_o(eq_mark));
    function [31:0] xs(input [31:0] s);
        begin
            s = s ^ (s << 13);
            s = s ^ (s >> 17);
            xs = s ^ (s << 5);
        end
    endfunction
    task automatic ck(input ok, input [8*12-1:0] msg);
        begin
            num_checks = num_checks + 1;
            if (!ok) begin
                failures = failures + 1;
                $display("[FAIL] %0t %0s", $time, msg);
            end
        end
    endtask
    task close_out;
        begin
            if (failures == 0 && num_checks > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task bus(input w, input [3:0] a, input [31:0] d);
        begin
            @(posedge mclk_i);
            {wr_i, rd_i, addr, wdata} <= {w, !w, a, d};
            @(posedge mclk_i);
            {wr_i, rd_i} <= 2'h0;
            @(negedge mclk_i);
        end
    endtask
    task cmd(input [1:0] op, input [1:0] i, input [1:0] o, input d);
        bus(1'b1, `REG_CMD, {19'h0, d, 2'h0, o, 2'h0, i, 2'h0, op});
    endtask
    task wbytes(input integer n);
        integer t;
        begin
            t = nb + n;
            repeat (n * 80) if (nb < t) @(posedge mclk_i);
        end
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        failures = failures + 1;
        close_out;
    end
    // Rebuild output bytes; a marked rise closes the eight bits before it
    always @(posedge mclk_i) begin
        pclk <= c_o[0];
        if (c_o[0] && !pclk) begin
            for (m = 0; m < 4; m = m + 1) shv[8 * m +: 8] <= {shv[8 * m +: 7], d_o[m]};
            bc <= m_o[0] ? 4'h1 : bc + 4'h1;
            if (m_o[0] && bc == 4'h8) begin
                last <= shv;
                nb <= nb + 1;
                if (watch) ck(shv[7:0] === exp0, "bcast byte");
            end
        end
    end
    initial begin
        {sys_rst_i, wr_i, rd_i, pclk, watch} = 5'h10;
        {addr, fail_in, bc, wdata, shv, last, exp0} = 0;
        nb = 0;
        failures = 0;
        num_checks = 0;
        seed = 32'hF261;
        for (k = 0; k < 4; k = k + 1) begin
            seed = xs(seed);
            pat[8 * k +: 8] = {k[1:0], seed[4:0], 1'b0};
        end
        repeat (8) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(negedge mclk_i);
        ck(src_o === 4'h1 && snk_o === 4'hF, "reset ena");
        bus(1'b0, `REG_CTRL, 32'h0);
        ck(rdata === `CTRL_RESET_VAL, "ctrl reset");
        bus(1'b1, 4'hF, seed);
        bus(1'b0, 4'hF, 32'h0);
        ck(rdata === 32'h0, "unmapped");
        wbytes(5);
        ck(last === {4{`IDLE_A_LAW}} && f_o === 4'h0, "idle a-law");
        bus(1'b1, `REG_CTRL, 32'hF01);
        wbytes(5);
        ck(last === {4{`IDLE_MU_LAW}}, "idle mu-law");
        for (k = 0; k < 4; k = k + 1) begin
            seed = xs(seed);
            bus(1'b1, `REG_CTRL, {20'h0, seed[3:0], 2'h0, k[1:0], 4'h0});
            @(negedge mclk_i);
            ck(src_o === 4'h1 << k && snk_o === seed[3:0], "adapt ena");
        end
        for (k = 0; k < 4; k = k + 1) begin
            seed = xs(seed);
            a_in = seed[1:0];
            a_out = {1'b1, seed[2]};
            cmd(`CMD_CONNECT, a_in, a_out, seed[3]);
            wbytes(5);
            ck(last[8 * a_out +: 8] === pat[8 * a_in +: 8], "routed");
            bus(1'b0, `REG_STATUS, 32'h0);
            ck((rdata & (32'h101 << a_out)) === {seed[3], 8'h1} << a_out, "status");
            cmd(`CMD_RELEASE, 2'h0, a_out, 1'b0);
            wbytes(5);
            ck(last[8 * a_out +: 8] === `IDLE_A_LAW, "released");
        end
        cmd(2'h0, 2'h1, 2'h3, 1'b0);
        cmd(2'h3, 2'h1, 2'h3, 1'b0);
        wbytes(5);
        ck(last[31:24] === `IDLE_A_LAW, "bad op");
        a_in = seed[5:4];
        exp0 = pat[8 * a_in +: 8];
        fail_in <= 4'h1 << a_in;
        cmd(`CMD_CONNECT, a_in, 2'h0, 1'b1);
        wbytes(5);
        ck(f_o === 4'h1, "fail fwd");
        watch <= 1'b1;
        cmd(`CMD_CONNECT, a_in, 2'h1, 1'b0);
        wbytes(5);
        ck(last[15:0] === {exp0, exp0}, "bcast copy");
        cmd(`CMD_RELEASE, 2'h0, 2'h1, 1'b0);
        wbytes(5);
        watch <= 1'b0;
        ck(last[15:8] === `IDLE_A_LAW, "bcast drop");
        close_out;
    end
endmodule // tb_timeslot_cross_connect
